// >>> bench/rlc_host_model.sv
// Host model: drives the register port at the falling clock edge.
// Assumes one-cycle strobes and read data valid one rising edge later.
`timescale 1ns/1ps
module rlc_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr = 8'h00,
  output logic            reg_wr = 1'b0,
  output logic            reg_rd = 1'b0,
  output logic      [7:0] reg_wdata = 8'h00
);
  // One write strobe across one rising edge; stale data is inverted after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask
  // Read strobe; data is taken once the strobe edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    d      = reg_rdata;
  endtask
endmodule // rlc_host_model

// >>> bench/rlc_result_regs_sva.sv
// Checker of the result block's register port and interrupt pin.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module rlc_result_regs_sva (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       conv_valid,
  input wire logic [2:0] conv_chan,
  input wire logic [9:0] conv_data,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       int_out
);
  logic lock_a;
  logic lim_dflt;
  // Shadow of the low-group lock, and whether channel 3 limits and masks are untouched
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lock_a   <= 1'b0;
      lim_dflt <= 1'b1;
    end else begin
      if (reg_rd && reg_addr == 8'h03) lock_a <= 1'b1;
      else if (reg_rd && reg_addr inside {[8'h06:8'h0B]}) lock_a <= 1'b0;
      if (reg_wr && reg_addr inside {8'h1E, 8'h2B, 8'h2C}) lim_dflt <= 1'b0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h02 |=> reg_rdata == 8'h00)
    else $error("reserved address read nonzero");
  a_status_upper: assert property (reg_rd && reg_addr inside {8'h00, 8'h01} |=>
    reg_rdata[7:6] == 2'h0) else $error("status upper bits set");
  a_lsb_updates: assert property (conv_valid && conv_chan == 3'h1 && !reg_rd ##1
    !conv_valid ##1 reg_rd && reg_addr == 8'h03 && !conv_valid |=>
    reg_rdata[3:2] == 2'($past(conv_data, 3))) else $error("low bits not stored");
  a_msb_updates: assert property (conv_valid && conv_chan == 3'h1 && !reg_rd && !lock_a
    ##1 !conv_valid ##1 reg_rd && reg_addr == 8'h07 && !conv_valid |=>
    reg_rdata == 8'($past(conv_data, 3) >> 2)) else $error("unlocked upper bits not stored");
  a_ain_low_trip: assert property (conv_valid && conv_chan == 3'h3 && lim_dflt
    && conv_data[9:2] == 8'h00 && !reg_wr ##1 !conv_valid && !reg_wr ##1
    reg_rd && reg_addr == 8'h01 |=> reg_rdata[1]) else $error("low limit equal did not trip");
  a_config_back: assert property (reg_wr && reg_addr == 8'h18 ##1 !reg_wr ##1
    reg_rd && reg_addr == 8'h18 |=> reg_rdata == ($past(reg_wdata, 3) & 8'h05))
    else $error("config readback wrong");
  a_int_cause: assert property ($changed(int_out) && $past(rst_n) |->
    $past(conv_valid, 2) || $past(reg_rd, 2) || $past(reg_wr, 2)) else $error("pin moved alone");
endmodule // rlc_result_regs_sva
bind rlc_result_regs rlc_result_regs_sva rlc_result_regs_sva_i (.core_clk(core_clk),
  .rst_n(rst_n), .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_data(conv_data),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .int_out(int_out));

// >>> bench/rlc_result_regs_tb_top.sv
// Self-checking bench of the result block with a host model on its register port.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED %0t: got %h want %h", $time, a, b); end end
module rlc_result_regs_tb_top;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       conv_valid = 1'b0;
  logic [2:0] conv_chan = 3'h0;
  logic [9:0] conv_data = 10'h000;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, r;
  logic       reg_wr, reg_rd, int_out;
  logic [9:0] d0, d1;
  int         num_errors = 0;
  int         n_compared = 0;
  int         cyc = 0;
  rlc_result_regs rlc_result_regs_i (.core_clk(core_clk), .rst_n(rst_n), .conv_valid(conv_valid),
    .conv_chan(conv_chan), .conv_data(conv_data), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .int_out(int_out));
  rlc_host_model rlc_host_model_i (.core_clk(core_clk), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  // 50 ns clock, and a ceiling well above the few hundred cycles the tests need
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // Expected {low trip, high trip} of a result against reset limits
  function automatic logic [1:0] trips(input int ch, input logic [9:0] d);
    logic [7:0] v, hi, lo;
    logic       sg;
    v  = d[9:2];
    hi = rlc_pkg::HI_RESET[ch];
    lo = rlc_pkg::LO_RESET[ch];
    sg = (ch == 1) || (ch == 2);
    trips[0] = sg ? ($signed(v) > $signed(hi)) : (v > hi);
    trips[1] = sg ? ($signed(v) <= $signed(lo)) : (v <= lo);
  endfunction
  task automatic conv(input int ch, input logic [9:0] d);
    @(negedge core_clk);
    conv_valid = 1'b1;
    conv_chan  = 3'(ch);
    conv_data  = d;
    @(negedge core_clk);
    conv_valid = 1'b0;
    conv_data  = ~d;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    rlc_host_model_i.rd(a, r);
    `CHK(r, e)
  endtask
  // Clear all flags, convert once, then compare the status pair and the pin
  task automatic trial(input int ch, input logic [9:0] d);
    logic [1:0] e;
    e = trips(ch, d);
    rlc_host_model_i.wr(8'h18, 8'h02);
    conv(ch, d);
    rlc_host_model_i.rd(ch < 3 ? 8'h00 : 8'h01, r);
    `CHK(2'(r >> (2 * (ch % 3))), e)
    `CHK(int_out, ~|e)
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h22d9eefe));
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    for (int c = 0; c < 6; c++) begin
      rdx(rlc_pkg::HI_ADDR[c], rlc_pkg::HI_RESET[c]);
      rdx(rlc_pkg::LO_ADDR[c], rlc_pkg::LO_RESET[c]);
    end
    rlc_host_model_i.wr(8'h06, 8'hA5);
    rdx(8'h06, rlc_pkg::RESULT_RESET);
    rdx(8'h02, 8'h00);
    $display("reset values done");
    d0 = 10'($urandom);
    d1 = 10'($urandom);
    conv(0, d0);
    conv(1, d1);
    rdx(8'h03, {4'h0, d1[1:0], d0[1:0]});
    conv(0, ~d0);
    conv(1, ~d1);
    conv(2, d1);
    rdx(8'h06, d0[9:2]);
    rdx(8'h07, d1[9:2]);
    rdx(8'h08, d1[9:2]);
    conv(1, ~d1);
    rdx(8'h07, ~d1[9:2]);
    rdx(8'h03, {4'h0, ~d1[1:0], ~d0[1:0]});
    rdx(8'h06, d0[9:2]);
    conv(0, d1);
    conv(1, d0);
    rdx(8'h06, d1[9:2]);
    rdx(8'h03, {4'h0, d0[1:0], d1[1:0]});
    $display("lock test done");
    trial(1, {8'h64, 2'h3});
    trial(1, {8'h65, 2'h0});
    trial(1, {8'hC9, 2'h3});
    trial(1, 10'h360);
    trial(0, {8'hC8, 2'h0});
    trial(0, {8'h62, 2'h3});
    trial(3, 10'h003);
    repeat (30) trial($urandom_range(5), 10'($urandom));
    $display("limit test done");
    rlc_host_model_i.wr(8'h18, 8'h06);
    rdx(8'h18, 8'h04);
    conv(2, 10'h200);
    rdx(8'h00, 8'h00);
    trial(1, {8'h70, 2'h0});
    rdx(8'h00, 8'h04);
    conv(1, 10'h000);
    rdx(8'h00, 8'h04);
    rdx(8'h00, 8'h00);
    conv(1, {8'h70, 2'h0});
    rlc_host_model_i.wr(8'h18, 8'h01);
    @(negedge core_clk);
    `CHK(int_out, 1'b1)
    rlc_host_model_i.wr(8'h1D, 8'h3F);
    conv(2, 10'h200);
    `CHK(int_out, 1'b0)
    rdx(8'h00, 8'h04);
    rdx(8'h18, 8'h01);
    $display("status test done");
    @(negedge core_clk);
    rst_n = 1'b0;
    @(negedge core_clk);
    rst_n = 1'b1;
    `CHK(int_out, 1'b1)
    rdx(8'h00, 8'h00);
    rdx(8'h1D, 8'h00);
    rdx(8'h18, 8'h00);
    $display("reset test done");
    tally_and_finish();
  end
endmodule // rlc_result_regs_tb_top

// >>> verilog/rlc_cmp_if.sv
// Carrier between the result block and its limit comparator.
// Assumes both ends sit in the same clock domain; the path is combinational.
`timescale 1ns/1ps
interface rlc_cmp_if;
  logic [rlc_pkg::LIM_W-1:0] value;
  logic [rlc_pkg::LIM_W-1:0] high_limit;
  logic [rlc_pkg::LIM_W-1:0] low_limit;
  logic                      is_signed;
  logic                      above;
  logic                      below;

  modport requester (output value, output high_limit, output low_limit,
                     output is_signed, input above, input below);
  modport checker_end (input value, input high_limit, input low_limit,
                       input is_signed, output above, output below);
endinterface

// >>> verilog/rlc_limit_check.sv
// Limit comparator for one 8-bit result against a high and a low limit.
// Assumes the requester has aligned the upper result bits with the limit.
`timescale 1ns/1ps
module rlc_limit_check #(
  parameter int W = rlc_pkg::LIM_W
) (
  rlc_cmp_if.checker_end cmp
);

  // The carrier is sized by the package, so another width cannot be served
  if (W != rlc_pkg::LIM_W) begin : g_bad_width
    $error("rlc_limit_check width differs from carrier width");
  end

  // Flip the sign bit so one unsigned compare serves two's complement too
  wire [W-1:0] sign_flip = {cmp.is_signed, {(W-1){1'b0}}};
  wire [W-1:0] v_key     = cmp.value ^ sign_flip;
  wire [W-1:0] hi_key    = cmp.high_limit ^ sign_flip;
  wire [W-1:0] lo_key    = cmp.low_limit ^ sign_flip;

  // High is strictly greater, low includes equality
  assign cmp.above = v_key > hi_key;
  assign cmp.below = v_key <= lo_key;

endmodule // rlc_limit_check

// >>> verilog/rlc_pkg.sv
// Shared constants of the result, limit and interrupt-status block.
// Assumes an 8-bit register port decoded from the serial link elsewhere.
package rlc_pkg;

  localparam int NUM_CH = 6;
  localparam int RES_W  = 10;
  localparam int LIM_W  = 8;
  localparam int LSB_W  = RES_W - LIM_W;
  localparam int NUM_FLAGS = 2 * NUM_CH;
  localparam int SIGN_POS  = RES_W - 1;

  // Channel numbers on the conversion input
  localparam logic [2:0] CH_SUPPLY    = 3'h0;
  localparam logic [2:0] CH_INNER_TMP = 3'h1;
  localparam logic [2:0] CH_OUTER_TMP = 3'h2;
  localparam logic [2:0] CH_LAST      = 3'h5;

  // Register addresses
  localparam logic [7:0] ADDR_FLAGS_FIRST  = 8'h00;
  localparam logic [7:0] ADDR_FLAGS_SECOND = 8'h01;
  localparam logic [7:0] ADDR_LSB_A        = 8'h03;
  localparam logic [7:0] ADDR_LSB_B        = 8'h04;
  localparam logic [7:0] ADDR_MSB_BASE     = 8'h06;
  localparam logic [7:0] ADDR_MSB_END      = 8'h0B;
  localparam logic [7:0] ADDR_CONFIG       = 8'h18;
  localparam logic [7:0] ADDR_MASK_FIRST   = 8'h1D;
  localparam logic [7:0] ADDR_MASK_SECOND  = 8'h1E;

  // Limit addresses and reset values per channel, high then low
  localparam logic [NUM_CH-1:0][7:0] HI_ADDR  = {8'h2F, 8'h2D, 8'h2B, 8'h27, 8'h25, 8'h23};
  localparam logic [NUM_CH-1:0][7:0] LO_ADDR  = {8'h30, 8'h2E, 8'h2C, 8'h28, 8'h26, 8'h24};
  localparam logic [NUM_CH-1:0][7:0] HI_RESET = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h64, 8'hC7};
  localparam logic [NUM_CH-1:0][7:0] LO_RESET = {8'h00, 8'h00, 8'h00, 8'h00, 8'hC9, 8'h62};

  // Channels whose low bits live in the second LSB register
  localparam logic [NUM_CH-1:0] IN_GROUP_B = 6'h3C;

  // Configuration bits
  localparam int CFG_POL_HIGH  = 0;
  localparam int CFG_SOFT_RST  = 1;
  localparam int CFG_OUTER_AIN = 2;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_RW    = 8'h05;

  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [1:0] LSB_RESET    = 2'h0;

endpackage

// >>> verilog/rlc_result_regs.sv
// Result registers, limit registers and interrupt status of the monitor.
// Assumes a decoded register port: one-cycle read and write strobes, 8-bit data.
// Assumes the converter delivers one 10-bit result per conv_valid pulse.
//
// Overview of operation
// - One result step is a quarter degree on temperature channels.
// - Temperature results are kept as 10-bit two's complement codes.
// - High limit trips on strictly greater, low limit on less or equal.
// - Limits are eight bits wide, results ten bits wide.
// - Unmasked out-of-limit compares set flags in status registers 00h and 01h.
// - Any flagged violation that is unmasked drives the interrupt pin to its selected active level.
// - Upper eight result bits sit in one register, low two in shared one.
// - Reading an LSB register first freezes its linked MSB registers.
// - Reading any frozen MSB register releases every frozen MSB register.
// - Reading an MSB register first does not freeze the LSB register.
// - First reads never freeze other registers of the same kind.
// - Status reads clear corrected flags only; software reset clears all.
`timescale 1ns/1ps
module rlc_result_regs (
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic                         conv_valid,
  input  wire logic [2:0]                   conv_chan,
  input  wire logic [rlc_pkg::RES_W-1:0]    conv_data,
  input  wire logic [7:0]                   reg_addr,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [7:0]                   reg_wdata,
  output logic      [7:0]                   reg_rdata,
  output logic                              int_out
);

  localparam int NCH = rlc_pkg::NUM_CH;
  localparam int NF  = rlc_pkg::NUM_FLAGS;
  localparam int LW  = rlc_pkg::LIM_W;
  localparam int SW  = rlc_pkg::LSB_W;

  // Status, mask and low-bit packing below assume six channels with two-bit remainders
  if (NCH != 6 || SW != 2) begin : g_bad_pkg
    $error("rlc_result_regs packing assumes six channels and two low bits");
  end

  logic [NCH-1:0][LW-1:0] msb_value;
  logic [NCH-1:0][SW-1:0] lsb_value;
  logic [NCH-1:0][LW-1:0] high_limit;
  logic [NCH-1:0][LW-1:0] low_limit;
  logic [NF-1:0]          flags;
  logic [NF-1:0]          cond;
  logic [NF-1:0]          mask;
  logic [7:0]             config_reg;
  logic                   lock_a;
  logic                   lock_b;
  logic [7:0]             next_rdata;

  rlc_cmp_if cmp_bus ();

  rlc_limit_check #(
    .W (LW)
  ) u_check (
    .cmp (cmp_bus)
  );

  // Incoming conversion decode; channel codes above the last are dropped
  wire conv_hit = conv_valid && (conv_chan <= rlc_pkg::CH_LAST);
  wire chan_is_temp = (conv_chan == rlc_pkg::CH_INNER_TMP) ||
                      ((conv_chan == rlc_pkg::CH_OUTER_TMP) &&
                       !config_reg[rlc_pkg::CFG_OUTER_AIN]);
  // Codes 6 and 7 would index past the limit arrays, so the comparator sees channel 0
  wire [2:0] lim_sel = conv_hit ? conv_chan : rlc_pkg::CH_SUPPLY;

  // Upper eight bits feed the comparator; temperature codes keep their sign bit on top
  assign cmp_bus.value      = conv_data[rlc_pkg::SIGN_POS -: LW];
  assign cmp_bus.high_limit = high_limit[lim_sel];
  assign cmp_bus.low_limit  = low_limit[lim_sel];
  assign cmp_bus.is_signed  = chan_is_temp;

  // Register port decode
  // Reads carry side effects (locks, flag clears), so each address decodes on its own
  wire rd_msb    = reg_rd && (reg_addr >= rlc_pkg::ADDR_MSB_BASE) &&
                   (reg_addr <= rlc_pkg::ADDR_MSB_END);
  wire rd_lsb_a  = reg_rd && (reg_addr == rlc_pkg::ADDR_LSB_A);
  wire rd_lsb_b  = reg_rd && (reg_addr == rlc_pkg::ADDR_LSB_B);
  wire rd_stat1  = reg_rd && (reg_addr == rlc_pkg::ADDR_FLAGS_FIRST);
  wire rd_stat2  = reg_rd && (reg_addr == rlc_pkg::ADDR_FLAGS_SECOND);
  wire wr_config = reg_wr && (reg_addr == rlc_pkg::ADDR_CONFIG);
  wire wr_mask1  = reg_wr && (reg_addr == rlc_pkg::ADDR_MASK_FIRST);
  wire wr_mask2  = reg_wr && (reg_addr == rlc_pkg::ADDR_MASK_SECOND);
  // Software reset is a pulse on the write, never a stored bit
  wire soft_rst  = wr_config && reg_wdata[rlc_pkg::CFG_SOFT_RST];

  // Freeze state: any MSB read releases both groups, an LSB read freezes its own
  // An MSB read wins over an LSB read; both in one cycle cannot occur on this port
  wire next_lock_a = rd_msb ? 1'b0 : (rd_lsb_a ? 1'b1 : lock_a);
  wire next_lock_b = rd_msb ? 1'b0 : (rd_lsb_b ? 1'b1 : lock_b);

  // Lock flops; an MSB read never sets a lock, so the LSB side stays free
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lock_a <= 1'b0;
      lock_b <= 1'b0;
    end else begin
      lock_a <= next_lock_a;
      lock_b <= next_lock_b;
    end
  end

  // Per-channel result and limit storage
  for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
    localparam logic [2:0] CH_CODE = 3'(ch);
    wire this_conv = conv_hit && (conv_chan == CH_CODE);
    // Group membership fixes which low-bit register freezes this channel
    wire frozen    = rlc_pkg::IN_GROUP_B[ch] ? lock_b : lock_a;
    wire wr_hi     = reg_wr && (reg_addr == rlc_pkg::HI_ADDR[ch]);
    wire wr_lo     = reg_wr && (reg_addr == rlc_pkg::LO_ADDR[ch]);

    // Result split; the low bits keep updating so a fresh pair can follow
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        msb_value[ch] <= rlc_pkg::RESULT_RESET;
        lsb_value[ch] <= rlc_pkg::LSB_RESET;
      end else if (this_conv) begin
        if (!frozen) begin
          msb_value[ch] <= conv_data[rlc_pkg::SIGN_POS -: LW];
        end
        lsb_value[ch] <= conv_data[SW-1:0];
      end
    end

    // Limit registers, eight bits against the ten-bit result
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        high_limit[ch] <= rlc_pkg::HI_RESET[ch];
        low_limit[ch]  <= rlc_pkg::LO_RESET[ch];
      end else begin
        if (wr_hi) high_limit[ch] <= reg_wdata;
        if (wr_lo) low_limit[ch]  <= reg_wdata;
      end
    end
  end

  // Per-flag status: even bit is the high trip, odd bit the low trip of a channel
  for (genvar f = 0; f < NF; f++) begin : g_flag
    localparam logic [2:0] CH_CODE = 3'(f / 2);
    wire this_conv = conv_hit && (conv_chan == CH_CODE);
    wire trip      = (f % 2 == 0) ? cmp_bus.above : cmp_bus.below;
    wire set_flag  = this_conv && trip && !mask[f];
    wire rd_clear  = (f < NF / 2) ? rd_stat1 : rd_stat2;
    // Only a condition that has since come back in range is cleared by a read
    wire clr_flag  = soft_rst || (rd_clear && !cond[f]);
    wire next_flag = set_flag || (flags[f] && !clr_flag);

    // cond keeps the latest compare, so a status read can tell a corrected condition
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        cond[f]  <= 1'b0;
        flags[f] <= 1'b0;
      end else begin
        if (this_conv) cond[f] <= trip;
        flags[f] <= next_flag;
      end
    end
  end

  // Mask and configuration registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mask       <= '0;
      config_reg <= rlc_pkg::CFG_RESET;
    end else begin
      if (wr_mask1) mask[NF/2-1:0]  <= reg_wdata[NF/2-1:0];
      if (wr_mask2) mask[NF-1:NF/2] <= reg_wdata[NF/2-1:0];
      // Only polarity and channel-2 mode are kept; the reset bit reads back zero
      if (wr_config) config_reg <= reg_wdata & rlc_pkg::CFG_RW;
    end
  end

  // Masking after the fact also quietens a flag already standing
  wire int_active = |(flags & ~mask);
  wire next_int   = config_reg[rlc_pkg::CFG_POL_HIGH] ? int_active : !int_active;

  // Registered pin, so a decode glitch on a strobe never reaches the outside
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      int_out <= 1'b1;
    end else begin
      int_out <= next_int;
    end
  end

  // Read selection; unmapped and reserved addresses answer zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      rlc_pkg::ADDR_FLAGS_FIRST:  next_rdata = {2'h0, flags[NF/2-1:0]};
      rlc_pkg::ADDR_FLAGS_SECOND: next_rdata = {2'h0, flags[NF-1:NF/2]};
      rlc_pkg::ADDR_LSB_A:        next_rdata = {4'h0, lsb_value[1], lsb_value[0]};
      rlc_pkg::ADDR_LSB_B:        next_rdata = {lsb_value[5], lsb_value[4],
                                                lsb_value[3], lsb_value[2]};
      rlc_pkg::ADDR_CONFIG:       next_rdata = config_reg;
      rlc_pkg::ADDR_MASK_FIRST:   next_rdata = {2'h0, mask[NF/2-1:0]};
      rlc_pkg::ADDR_MASK_SECOND:  next_rdata = {2'h0, mask[NF-1:NF/2]};
      default: begin
        // Results and limits sit on scattered addresses, so the loop searches them
        for (int c = 0; c < NCH; c++) begin
          if (reg_addr == rlc_pkg::ADDR_MSB_BASE + 8'(c)) next_rdata = msb_value[c];
          if (reg_addr == rlc_pkg::HI_ADDR[c]) next_rdata = high_limit[c];
          if (reg_addr == rlc_pkg::LO_ADDR[c]) next_rdata = low_limit[c];
        end
      end
    endcase
  end

  // Read data is captured on the strobe and held until the next read
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // rlc_result_regs
